// >>> rtl/rbcr_pkg.sv
// rbcr_pkg: offsets, field positions, reset values and timing counts for the
// rail b / rail c regulator configuration bank.
// assumes byte-wide registers on an 8-bit internal register access port.
package rbcr_pkg;

  // byte offsets on the internal register port
  localparam logic [7:0] RBCR_ADDR_RSVD_A   = 8'h23;
  localparam logic [7:0] RBCR_ADDR_RSVD_B   = 8'h24;
  localparam logic [7:0] RBCR_ADDR_B_VOLT   = 8'h25;
  localparam logic [7:0] RBCR_ADDR_B_THRESH = 8'h26;
  localparam logic [7:0] RBCR_ADDR_C_VOLT   = 8'h27;
  localparam logic [7:0] RBCR_ADDR_C_THRESH = 8'h28;

  // field positions
  localparam int RBCR_VCODE_LSB  = 1;
  localparam int RBCR_PGLOW_BIT  = 0;
  localparam int RBCR_PGHIGH_LSB = 6;
  localparam int RBCR_OV_LSB     = 4;
  localparam int RBCR_UVLO_LSB   = 2;
  localparam int RBCR_STOP_LSB   = 0;

  // reset values
  localparam logic [6:0] RBCR_VCODE_RST  = 7'h3c;
  localparam logic       RBCR_PGLOW_RST  = 1'b0;
  localparam logic [1:0] RBCR_PGHIGH_RST = 2'h1;
  localparam logic [1:0] RBCR_OV_RST     = 2'h2;
  localparam logic [1:0] RBCR_UVLO_RST   = 2'h0;
  localparam logic [1:0] RBCR_STOP_RST   = 2'h3;
  localparam logic [7:0] RBCR_RSVD_VALUE = 8'h00;

  // voltage base and step in mV
  localparam logic [11:0] RBCR_B_BASE_MV = 12'd800;
  localparam logic [11:0] RBCR_C_BASE_MV = 12'd1500;
  localparam logic [11:0] RBCR_STEP_MV   = 12'd5;

  // percentages held in tenths of a percent
  localparam logic [6:0] RBCR_P25  = 7'd25;
  localparam logic [6:0] RBCR_P50  = 7'd50;
  localparam logic [6:0] RBCR_P75  = 7'd75;
  localparam logic [6:0] RBCR_P100 = 7'd100;
  localparam logic [6:0] RBCR_P125 = 7'd125;

  // soft-stop base time in microseconds and the clock rate
  localparam int RBCR_STOP_BASE_US = 500;
  localparam int RBCR_CLK_MHZ      = 250;
  localparam int RBCR_STOP_BASE_CYC = RBCR_STOP_BASE_US * RBCR_CLK_MHZ;

  typedef enum logic [1:0] { RBCR_IDLE, RBCR_RAMP, RBCR_DONE } rbcr_stop_t;

endpackage : rbcr_pkg

// >>> rtl/rbcr_decode.sv
// rbcr_decode: turns one rail's threshold codes into target millivolts and
// window offsets in tenths of a percent, registered.
// assumes the codes come from registers on the same clock.
`timescale 1ns/100ps
module rbcr_decode
  import rbcr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [11:0] base_mv,
  input  wire logic [6:0]  voltage_code,
  input  wire logic        pg_low_sel,
  input  wire logic [1:0]  pg_high_sel,
  input  wire logic [1:0]  ov_sel,
  input  wire logic [1:0]  uvlo_sel,
  output logic      [11:0] target_mv,
  output logic      [6:0]  pg_low_pct,
  output logic      [6:0]  pg_high_pct,
  output logic      [6:0]  ov_pct,
  output logic      [6:0]  uvlo_pct
);

  logic [11:0] next_target_mv;
  logic [6:0]  next_pg_low_pct;
  logic [6:0]  next_pg_high_pct;
  logic [6:0]  next_ov_pct;
  logic [6:0]  next_uvlo_pct;

  // code lookups; the tables are not monotonic, so no arithmetic shortcut
  always_comb begin
    next_target_mv   = base_mv + 12'(voltage_code * RBCR_STEP_MV);
    next_pg_low_pct  = pg_low_sel ? RBCR_P75 : RBCR_P50;
    case (pg_high_sel)
      2'h0:    next_pg_high_pct = RBCR_P50;
      2'h1:    next_pg_high_pct = RBCR_P75;
      2'h2:    next_pg_high_pct = RBCR_P100;
      default: next_pg_high_pct = RBCR_P25;
    endcase
    case (ov_sel)
      2'h0:    next_ov_pct = RBCR_P75;
      2'h1:    next_ov_pct = RBCR_P100;
      2'h2:    next_ov_pct = RBCR_P125;
      default: next_ov_pct = RBCR_P50;
    endcase
    case (uvlo_sel)
      2'h0:    next_uvlo_pct = RBCR_P100;
      2'h1:    next_uvlo_pct = RBCR_P125;
      2'h2:    next_uvlo_pct = RBCR_P50;
      default: next_uvlo_pct = RBCR_P75;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      target_mv   <= 12'h000;
      pg_low_pct  <= 7'h00;
      pg_high_pct <= 7'h00;
      ov_pct      <= 7'h00;
      uvlo_pct    <= 7'h00;
    end else begin
      target_mv   <= next_target_mv;
      pg_low_pct  <= next_pg_low_pct;
      pg_high_pct <= next_pg_high_pct;
      ov_pct      <= next_ov_pct;
      uvlo_pct    <= next_uvlo_pct;
    end
  end

endmodule : rbcr_decode

// >>> rtl/rbcr_soft_stop.sv
// rbcr_soft_stop: times the ramp-down after a rail enable falls.
// assumes rail_en is synchronous to sys_clk; the duration is
// base_cyc shifted left by the two-bit select.
`timescale 1ns/100ps
module rbcr_soft_stop
  import rbcr_pkg::*;
#(
  parameter int BASE_CYC = RBCR_STOP_BASE_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       rail_en,
  input  wire logic [1:0] stop_sel,
  output logic            ramping,
  output logic            done
);

  rbcr_stop_t  state;
  rbcr_stop_t  next_state;
  logic [23:0] count;
  logic [23:0] next_count;
  logic        en_q;
  logic        next_ramping;
  logic        next_done;

  // a re-enable aborts the ramp; the regulator owns the rail again
  always_comb begin
    next_state   = state;
    next_count   = count;
    next_done    = 1'b0;
    case (state)
      RBCR_IDLE: begin
        if (en_q && !rail_en) begin
          next_state = RBCR_RAMP;
          next_count = 24'(BASE_CYC << stop_sel) - 24'h000001;
        end
      end
      RBCR_RAMP: begin
        if (rail_en) begin
          next_state = RBCR_IDLE;
        end else if (count == 24'h000000) begin
          next_state = RBCR_DONE;
          next_done  = 1'b1;
        end else begin
          next_count = count - 24'h000001;
        end
      end
      RBCR_DONE: next_state = RBCR_IDLE;
      default:   next_state = RBCR_IDLE;
    endcase
    next_ramping = (next_state == RBCR_RAMP);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state   <= RBCR_IDLE;
      count   <= 24'h000000;
      en_q    <= 1'b0;
      ramping <= 1'b0;
      done    <= 1'b0;
    end else begin
      state   <= next_state;
      count   <= next_count;
      en_q    <= rail_en;
      ramping <= next_ramping;
      done    <= next_done;
    end
  end

endmodule : rbcr_soft_stop

// >>> rtl/rbcr_regs.sv
// rbcr_regs: configuration bank for rails b and c at byte offsets 23h..28h.
// assumes a single-cycle internal register port driven by the serial bus
// front end on sys_clk; reads answer one cycle after the strobe.
`timescale 1ns/100ps
module rbcr_regs
  import rbcr_pkg::*;
#(
  parameter int STOP_BASE_CYC = RBCR_STOP_BASE_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic                  rail_b_en,
  input  wire logic                  rail_c_en,
  output logic      [6:0]            rail_b_voltage_code,
  output logic                       rail_b_pg_low_offset,
  output logic      [1:0]            rail_b_pg_high_offset,
  output logic      [1:0]            rail_b_ov_offset,
  output logic      [1:0]            rail_b_uvlo_offset,
  output logic      [1:0]            rail_b_ramp_down_time,
  output logic      [6:0]            rail_c_voltage_code,
  output logic                       rail_c_pg_low_offset,
  output logic      [1:0]            rail_c_pg_high_offset,
  output logic      [1:0]            rail_c_ov_offset,
  output logic      [1:0]            rail_c_uvlo_offset,
  output logic      [1:0]            rail_c_ramp_down_time,
  output logic      [11:0]           rail_b_target_mv,
  output logic      [11:0]           rail_c_target_mv,
  output logic      [6:0]            rail_b_pg_low_pct,
  output logic      [6:0]            rail_b_pg_high_pct,
  output logic      [6:0]            rail_b_ov_pct,
  output logic      [6:0]            rail_b_uvlo_pct,
  output logic      [6:0]            rail_c_pg_low_pct,
  output logic      [6:0]            rail_c_pg_high_pct,
  output logic      [6:0]            rail_c_ov_pct,
  output logic      [6:0]            rail_c_uvlo_pct,
  output logic                       rail_b_ramping,
  output logic                       rail_c_ramping,
  output logic                       rail_b_stop_done,
  output logic                       rail_c_stop_done
);

  // rail b and rail c use different base voltages but the same layout
  function automatic logic [7:0] pack_volt(input logic [6:0] code, input logic pgl);
    pack_volt = {code, pgl};
  endfunction : pack_volt

  function automatic logic [7:0] pack_thresh(input logic [1:0] pgh, input logic [1:0] ov,
                                             input logic [1:0] uv, input logic [1:0] st);
    pack_thresh = {pgh, ov, uv, st};
  endfunction : pack_thresh

  logic [7:0] b_volt;
  logic [7:0] b_thresh;
  logic [7:0] c_volt;
  logic [7:0] c_thresh;
  logic [7:0] next_b_volt;
  logic [7:0] next_b_thresh;
  logic [7:0] next_c_volt;
  logic [7:0] next_c_thresh;
  logic [7:0] next_rdata;
  logic       next_rvalid;

  localparam logic [7:0] B_VOLT_RST   = {RBCR_VCODE_RST, RBCR_PGLOW_RST};
  localparam logic [7:0] THRESH_RST   = {RBCR_PGHIGH_RST, RBCR_OV_RST,
                                         RBCR_UVLO_RST, RBCR_STOP_RST};

  // write decode; every bit of the four live bytes is writable
  always_comb begin
    next_b_volt   = b_volt;
    next_b_thresh = b_thresh;
    next_c_volt   = c_volt;
    next_c_thresh = c_thresh;
    if (reg_wr) begin
      case (reg_addr)
        RBCR_ADDR_B_VOLT:   next_b_volt   = reg_wdata;
        RBCR_ADDR_B_THRESH: next_b_thresh = reg_wdata;
        RBCR_ADDR_C_VOLT:   next_c_volt   = reg_wdata;
        RBCR_ADDR_C_THRESH: next_c_thresh = reg_wdata;
        default: ; // reserved and unmapped writes are dropped
      endcase
    end
  end

  // read mux; reserved and unmapped bytes return zero
  always_comb begin
    next_rvalid = reg_rd;
    next_rdata  = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        RBCR_ADDR_B_VOLT:   next_rdata = pack_volt(b_volt[7:1], b_volt[0]);
        RBCR_ADDR_B_THRESH: next_rdata = pack_thresh(b_thresh[7:6], b_thresh[5:4],
                                                     b_thresh[3:2], b_thresh[1:0]);
        RBCR_ADDR_C_VOLT:   next_rdata = pack_volt(c_volt[7:1], c_volt[0]);
        RBCR_ADDR_C_THRESH: next_rdata = pack_thresh(c_thresh[7:6], c_thresh[5:4],
                                                     c_thresh[3:2], c_thresh[1:0]);
        RBCR_ADDR_RSVD_A:   next_rdata = RBCR_RSVD_VALUE;
        RBCR_ADDR_RSVD_B:   next_rdata = RBCR_RSVD_VALUE;
        default:            next_rdata = RBCR_RSVD_VALUE;
      endcase
    end
  end

  // storage and read port
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      b_volt     <= B_VOLT_RST;
      b_thresh   <= THRESH_RST;
      c_volt     <= B_VOLT_RST;
      c_thresh   <= THRESH_RST;
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      b_volt     <= next_b_volt;
      b_thresh   <= next_b_thresh;
      c_volt     <= next_c_volt;
      c_thresh   <= next_c_thresh;
      reg_rdata  <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  // field outputs straight from the storage flops
  assign rail_b_voltage_code   = b_volt[7:RBCR_VCODE_LSB];
  assign rail_b_pg_low_offset  = b_volt[RBCR_PGLOW_BIT];
  assign rail_b_pg_high_offset = b_thresh[RBCR_PGHIGH_LSB +: 2];
  assign rail_b_ov_offset      = b_thresh[RBCR_OV_LSB +: 2];
  assign rail_b_uvlo_offset    = b_thresh[RBCR_UVLO_LSB +: 2];
  assign rail_b_ramp_down_time = b_thresh[RBCR_STOP_LSB +: 2];
  assign rail_c_voltage_code   = c_volt[7:RBCR_VCODE_LSB];
  assign rail_c_pg_low_offset  = c_volt[RBCR_PGLOW_BIT];
  assign rail_c_pg_high_offset = c_thresh[RBCR_PGHIGH_LSB +: 2];
  assign rail_c_ov_offset      = c_thresh[RBCR_OV_LSB +: 2];
  assign rail_c_uvlo_offset    = c_thresh[RBCR_UVLO_LSB +: 2];
  assign rail_c_ramp_down_time = c_thresh[RBCR_STOP_LSB +: 2];

  // decoded targets and window offsets, one per rail
  rbcr_decode u_dec_b (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .base_mv      (RBCR_B_BASE_MV),
    .voltage_code (b_volt[7:1]),
    .pg_low_sel   (b_volt[0]),
    .pg_high_sel  (b_thresh[7:6]),
    .ov_sel       (b_thresh[5:4]),
    .uvlo_sel     (b_thresh[3:2]),
    .target_mv    (rail_b_target_mv),
    .pg_low_pct   (rail_b_pg_low_pct),
    .pg_high_pct  (rail_b_pg_high_pct),
    .ov_pct       (rail_b_ov_pct),
    .uvlo_pct     (rail_b_uvlo_pct)
  );

  rbcr_decode u_dec_c (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .base_mv      (RBCR_C_BASE_MV),
    .voltage_code (c_volt[7:1]),
    .pg_low_sel   (c_volt[0]),
    .pg_high_sel  (c_thresh[7:6]),
    .ov_sel       (c_thresh[5:4]),
    .uvlo_sel     (c_thresh[3:2]),
    .target_mv    (rail_c_target_mv),
    .pg_low_pct   (rail_c_pg_low_pct),
    .pg_high_pct  (rail_c_pg_high_pct),
    .ov_pct       (rail_c_ov_pct),
    .uvlo_pct     (rail_c_uvlo_pct)
  );

  // rail c's shortest ramp is twice rail b's, so its base doubles
  rbcr_soft_stop #(
    .BASE_CYC (STOP_BASE_CYC)
  ) u_stop_b (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .rail_en  (rail_b_en),
    .stop_sel (b_thresh[1:0]),
    .ramping  (rail_b_ramping),
    .done     (rail_b_stop_done)
  );

  rbcr_soft_stop #(
    .BASE_CYC (2 * STOP_BASE_CYC)
  ) u_stop_c (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .rail_en  (rail_c_en),
    .stop_sel (c_thresh[1:0]),
    .ramping  (rail_c_ramping),
    .done     (rail_c_stop_done)
  );

  // checks
  sequence s_rsvd_read;
    reg_rd && (reg_addr == RBCR_ADDR_RSVD_A || reg_addr == RBCR_ADDR_RSVD_B);
  endsequence

  sequence s_b_write;
    reg_wr && reg_addr == RBCR_ADDR_B_VOLT;
  endsequence

  sequence s_b_abort;
    rail_b_ramping && rail_b_en;
  endsequence

  chk_rsvd_read_zero: assert property (@(posedge sys_clk) disable iff (rst)
    s_rsvd_read |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("reserved byte read not zero");

  chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && (reg_addr < RBCR_ADDR_RSVD_A || reg_addr > RBCR_ADDR_C_THRESH)
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  chk_b_code_write: assert property (@(posedge sys_clk) disable iff (rst)
    s_b_write |=> rail_b_voltage_code == $past(reg_wdata[7:1]) ##1
    rail_b_target_mv == RBCR_B_BASE_MV + 12'($past(rail_b_voltage_code) * RBCR_STEP_MV))
    else $error("rail b code or target wrong");

  chk_c_target_mv: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(rail_c_voltage_code) |=>
    rail_c_target_mv == RBCR_C_BASE_MV + 12'($past(rail_c_voltage_code) * RBCR_STEP_MV))
    else $error("rail c target wrong");

  chk_b_pg_low: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(rail_b_pg_low_offset) |=>
    rail_b_pg_low_pct == ($past(rail_b_pg_low_offset) ? RBCR_P75 : RBCR_P50))
    else $error("rail b pg low wrong");

  chk_c_pg_low: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(rail_c_pg_low_offset) |=>
    rail_c_pg_low_pct == ($past(rail_c_pg_low_offset) ? RBCR_P75 : RBCR_P50))
    else $error("rail c pg low wrong");

  chk_b_pg_high: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(rail_b_pg_high_offset) && rail_b_pg_high_offset == 2'h3 |=>
    rail_b_pg_high_pct == 7'd25)
    else $error("rail b pg high wrong");

  chk_c_ov_code: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(rail_c_ov_offset) && rail_c_ov_offset == 2'h2 |=> rail_c_ov_pct == 7'd125)
    else $error("rail c ov wrong");

  chk_b_uvlo_code: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(rail_b_uvlo_offset) && rail_b_uvlo_offset == 2'h0 |=> rail_b_uvlo_pct == 7'd100)
    else $error("rail b uvlo wrong");

  chk_c_thresh_addr: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == RBCR_ADDR_B_THRESH |=> $stable(rail_c_ramp_down_time))
    else $error("rail c thresholds hit by 26h write");

  // table entries not covered above; the codings are not monotonic
  chk_c_pg_high_code: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(rail_c_pg_high_offset) && rail_c_pg_high_offset == 2'h0 |=>
    rail_c_pg_high_pct == RBCR_P50)
    else $error("rail c pg high wrong");

  chk_b_ov_code: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(rail_b_ov_offset) && rail_b_ov_offset == 2'h3 |=> rail_b_ov_pct == RBCR_P50)
    else $error("rail b ov wrong");

  chk_c_uvlo_code: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(rail_c_uvlo_offset) && rail_c_uvlo_offset == 2'h1 |=>
    rail_c_uvlo_pct == RBCR_P125)
    else $error("rail c uvlo wrong");

  // a re-enable must cut the ramp short with no done pulse
  chk_b_stop_abort: assert property (@(posedge sys_clk) disable iff (rst)
    s_b_abort |=> !rail_b_ramping && !rail_b_stop_done)
    else $error("rail b ramp not aborted");

  // the ramp only starts after the enable was seen low
  chk_c_stop_start: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(rail_c_ramping) |-> !$past(rail_c_en))
    else $error("rail c ramp started while enabled");

endmodule : rbcr_regs

// >>> tb/rbcr_host.sv
// rbcr_host: host side of the internal register port, one byte per strobe.
// assumes callers enter op at a falling edge of sys_clk.
`timescale 1ns/100ps
module rbcr_host (
  input  wire logic       sys_clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one strobe cycle; keep leaves the lines up for a back-to-back follower
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                    input bit keep, output logic [7:0] q, output logic vld);
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    q = reg_rdata;
    vld = reg_rvalid;
    if (!keep) begin
      // released lines show the inverse, so a stale value never looks live
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      @(negedge sys_clk);
    end
  endtask : op
endmodule : rbcr_host

// >>> tb/rbcr_regs_test.sv
// rbcr_regs_test: self-checking bench for the rail b / rail c config bank.
// assumes rbcr_pkg and rbcr_host are compiled first; soft-stop base shortened.
`timescale 1ns/100ps
module rbcr_regs_test;
  import rbcr_pkg::*;
  localparam int STOP_BASE = 4;
  localparam int CYC_LIMIT = 20000;
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdback;} rbcr_row_t;

  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        rail_b_en = 1'b1;
  logic        rail_c_en = 1'b1;
  logic        reg_wr, reg_rd, reg_rvalid;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [6:0]  rail_b_voltage_code, rail_c_voltage_code;
  logic        rail_b_pg_low_offset, rail_c_pg_low_offset;
  logic [1:0]  rail_b_pg_high_offset, rail_b_ov_offset, rail_b_uvlo_offset, rail_b_ramp_down_time;
  logic [1:0]  rail_c_pg_high_offset, rail_c_ov_offset, rail_c_uvlo_offset, rail_c_ramp_down_time;
  logic [11:0] rail_b_target_mv, rail_c_target_mv;
  logic [6:0]  rail_b_pg_low_pct, rail_b_pg_high_pct, rail_b_ov_pct, rail_b_uvlo_pct;
  logic [6:0]  rail_c_pg_low_pct, rail_c_pg_high_pct, rail_c_ov_pct, rail_c_uvlo_pct;
  logic        rail_b_ramping, rail_c_ramping, rail_b_stop_done, rail_c_stop_done;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [7:0]  sh[4] = '{8'h78, 8'h63, 8'h78, 8'h63};
  logic [6:0]  hi_t[4] = '{RBCR_P50, RBCR_P75, RBCR_P100, RBCR_P25};
  logic [6:0]  ov_t[4] = '{RBCR_P75, RBCR_P100, RBCR_P125, RBCR_P50};
  logic [6:0]  uv_t[4] = '{RBCR_P100, RBCR_P125, RBCR_P50, RBCR_P75};
  rbcr_row_t   rows[17] = '{
    '{8'h25, 8'h00, 8'h00}, '{8'h25, 8'hff, 8'hff}, '{8'h25, 8'h79, 8'h79}, '{8'h26, 8'h00, 8'h00},
    '{8'h26, 8'h55, 8'h55}, '{8'h26, 8'haa, 8'haa}, '{8'h26, 8'hff, 8'hff}, '{8'h27, 8'h00, 8'h00},
    '{8'h27, 8'hfd, 8'hfd}, '{8'h27, 8'hff, 8'hff}, '{8'h28, 8'h00, 8'h00}, '{8'h28, 8'h55, 8'h55},
    '{8'h28, 8'haa, 8'haa}, '{8'h28, 8'hff, 8'hff}, '{8'h23, 8'hff, 8'h00}, '{8'h24, 8'ha5, 8'h00},
    '{8'h29, 8'hff, 8'h00}};

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  rbcr_host host_u (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  rbcr_regs #(.STOP_BASE_CYC(STOP_BASE)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rail_b_en(rail_b_en),
    .rail_c_en(rail_c_en), .rail_b_voltage_code(rail_b_voltage_code),
    .rail_b_pg_low_offset(rail_b_pg_low_offset), .rail_b_pg_high_offset(rail_b_pg_high_offset),
    .rail_b_ov_offset(rail_b_ov_offset), .rail_b_uvlo_offset(rail_b_uvlo_offset),
    .rail_b_ramp_down_time(rail_b_ramp_down_time), .rail_c_voltage_code(rail_c_voltage_code),
    .rail_c_pg_low_offset(rail_c_pg_low_offset), .rail_c_pg_high_offset(rail_c_pg_high_offset),
    .rail_c_ov_offset(rail_c_ov_offset), .rail_c_uvlo_offset(rail_c_uvlo_offset),
    .rail_c_ramp_down_time(rail_c_ramp_down_time), .rail_b_target_mv(rail_b_target_mv),
    .rail_c_target_mv(rail_c_target_mv), .rail_b_pg_low_pct(rail_b_pg_low_pct),
    .rail_b_pg_high_pct(rail_b_pg_high_pct), .rail_b_ov_pct(rail_b_ov_pct),
    .rail_b_uvlo_pct(rail_b_uvlo_pct), .rail_c_pg_low_pct(rail_c_pg_low_pct),
    .rail_c_pg_high_pct(rail_c_pg_high_pct), .rail_c_ov_pct(rail_c_ov_pct),
    .rail_c_uvlo_pct(rail_c_uvlo_pct), .rail_b_ramping(rail_b_ramping),
    .rail_c_ramping(rail_c_ramping), .rail_b_stop_done(rail_b_stop_done),
    .rail_c_stop_done(rail_c_stop_done));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("counts: checked=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // every field and decoded value against the shadow copy
  task automatic chk_rails;
    check(rail_b_voltage_code, sh[0][7:1]);
    check(rail_b_target_mv, 12'h320 + 12'h005 * {5'h00, sh[0][7:1]});
    check(rail_b_pg_low_offset, sh[0][0]);
    check(rail_b_pg_high_offset, sh[1][7:6]);
    check(rail_b_ov_offset, sh[1][5:4]);
    check(rail_b_uvlo_offset, sh[1][3:2]);
    check(rail_b_pg_low_pct, sh[0][0] ? RBCR_P75 : RBCR_P50);
    check(rail_b_pg_high_pct, hi_t[sh[1][7:6]]);
    check(rail_b_ov_pct, ov_t[sh[1][5:4]]);
    check(rail_b_uvlo_pct, uv_t[sh[1][3:2]]);
    check(rail_b_ramp_down_time, sh[1][1:0]);
    check(rail_c_voltage_code, sh[2][7:1]);
    check(rail_c_pg_low_offset, sh[2][0]);
    check(rail_c_pg_high_offset, sh[3][7:6]);
    check(rail_c_ov_offset, sh[3][5:4]);
    check(rail_c_uvlo_offset, sh[3][3:2]);
    check(rail_c_target_mv, 12'h5dc + 12'h005 * {5'h00, sh[2][7:1]});
    check(rail_c_pg_low_pct, sh[2][0] ? RBCR_P75 : RBCR_P50);
    check(rail_c_pg_high_pct, hi_t[sh[3][7:6]]);
    check(rail_c_ov_pct, ov_t[sh[3][5:4]]);
    check(rail_c_uvlo_pct, uv_t[sh[3][3:2]]);
    check(rail_c_ramp_down_time, sh[3][1:0]);
  endtask : chk_rails

  // read all six bytes; reserved ones must come back zero
  task automatic rd_all;
    logic [7:0] q;
    logic       v;
    for (int i = 0; i < 6; i++) begin
      host_u.op(1'b0, 1'b1, 8'h23 + 8'(i), 8'h00, 1'b0, q, v);
      check(v, 1'b1);
      check(q, (i < 2) ? 8'h00 : sh[i - 2]);
    end
  endtask : rd_all

  // soft-stop length for one rail and select, done expected base shl sel plus one cycles after the enable falls
  task automatic stop_run(input bit c, input logic [1:0] sel);
    logic [7:0] q;
    logic       v;
    int         k;
    host_u.op(1'b1, 1'b0, c ? 8'h28 : 8'h26, {sh[c ? 3 : 1][7:2], sel}, 1'b0, q, v);
    sh[c ? 3 : 1][1:0] = sel;
    if (c) rail_c_en = 1'b0;
    else rail_b_en = 1'b0;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while ((c ? rail_c_stop_done : rail_b_stop_done) !== 1'b1 && k < 300);
    check(16'(k), 16'((((c ? 2 : 1) * STOP_BASE) << sel) + 1));
    check(c ? rail_c_ramping : rail_b_ramping, 1'b0);
    rail_b_en = 1'b1;
    rail_c_en = 1'b1;
    @(negedge sys_clk);
    check(c ? rail_c_stop_done : rail_b_stop_done, 1'b0);
    @(negedge sys_clk);
  endtask : stop_run

  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == CYC_LIMIT) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    logic [7:0] q;
    logic       v;
    int         k;
    repeat (8) @(negedge sys_clk);
    check(reg_rvalid, 1'b0);
    check(rail_b_ramping, 1'b0);
    rst = 1'b0;
    @(negedge sys_clk);
    chk_rails();
    rd_all();
    $display("reset defaults done");
    foreach (rows[i]) begin
      host_u.op(1'b1, 1'b0, rows[i].addr, rows[i].wdata, 1'b0, q, v);
      host_u.op(1'b0, 1'b1, rows[i].addr, 8'h00, 1'b0, q, v);
      check(q, rows[i].rdback);
      if (rows[i].addr inside {[8'h25:8'h28]}) sh[rows[i].addr - 8'h25] = rows[i].wdata;
      chk_rails();
      $display("row %0d done", i);
    end
    // back-to-back writes, then read and write one byte in the same cycle
    host_u.op(1'b1, 1'b0, 8'h25, 8'h11, 1'b1, q, v);
    host_u.op(1'b1, 1'b0, 8'h27, 8'h22, 1'b0, q, v);
    host_u.op(1'b1, 1'b1, 8'h25, 8'h33, 1'b0, q, v);
    check(q, 8'h11);
    sh[0] = 8'h33;
    sh[2] = 8'h22;
    host_u.op(1'b0, 1'b1, 8'h25, 8'h00, 1'b0, q, v);
    check(q, 8'h33);
    chk_rails();
    $display("back-to-back done");
    for (int s = 0; s < 4; s++) begin
      stop_run(1'b0, 2'(s));
      stop_run(1'b1, 2'(s));
    end
    $display("soft-stop lengths done");
    // re-enable in mid-ramp must abort with no done pulse
    rail_b_en = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(rail_b_ramping, 1'b1);
    rail_b_en = 1'b1;
    k = 0;
    repeat (80) begin
      @(negedge sys_clk);
      if (rail_b_stop_done === 1'b1) k++;
    end
    check(16'(k), 16'h0000);
    check(rail_b_ramping, 1'b0);
    $display("abort done");
    // second reset in mid-run brings every default back
    host_u.op(1'b1, 1'b0, 8'h28, 8'h00, 1'b0, q, v);
    rst = 1'b1;
    #1;
    check(rail_c_ov_offset, RBCR_OV_RST);
    check(rail_c_uvlo_offset, RBCR_UVLO_RST);
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    sh = '{8'h78, 8'h63, 8'h78, 8'h63};
    @(negedge sys_clk);
    chk_rails();
    rd_all();
    $display("second reset done");
    wrap_up();
  end
endmodule : rbcr_regs_test
